// ===== bench/tls_host_model.sv
// Purpose: host side of the register port, byte reads and writes
// Assumes: one clock, the slave never stalls, strobes are one cycle
// Notes:   a released address or data bus shows the inverse of its last value
`timescale 1ns/10ps
`default_nettype none

module tls_host_model (
   // clock
   input  wire logic       i_mclk,
   // register port
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata,
   output logic            o_wr,
   output logic            o_rd,
   input  wire logic [7:0] i_rdata
);

   // idle bus at time zero
   initial begin
      o_addr  = 8'h00;
      o_wdata = 8'h00;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end

   // one-cycle write, bus scrambled afterwards so stale values never help
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      o_wr    <= 1'b1;
      o_addr  <= a;
      o_wdata <= d;
      @(posedge i_mclk);
      o_wr    <= 1'b0;
      o_addr  <= ~a;
      o_wdata <= ~d;
   endtask : write_reg

   // read data stand only in the cycle after the strobe, taken mid-cycle
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      o_rd   <= 1'b1;
      o_addr <= a;
      @(posedge i_mclk);
      o_rd   <= 1'b0;
      o_addr <= ~a;
      @(negedge i_mclk);
      d = i_rdata;
   endtask : read_reg

endmodule : tls_host_model
`default_nettype wire

// ===== bench/tls_temp_limit_status_regs_bench.sv
// Purpose: self-checking bench of the limit status register bank
// Assumes: host model drives the register port, bench drives conversions
// Notes:   expected bytes worked out from reset limits and limits written by the bench
`timescale 1ns/10ps
`default_nettype none

module tls_temp_limit_status_regs_bench;
   logic       mclk;
   logic       rst_b;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       conv;
   logic [7:0] loc_t;
   logic [7:0] r1_t;
   logic [7:0] r2_t;
   logic [7:0] a9_t;
   logic [1:0] ovr;
   logic       irq;
   int         err_total;
   int         checks;

   // design and host
   tls_temp_limit_status_regs #(.NCH(2)) uut (
      .i_mclk(mclk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_conv_valid(conv), .i_local_temp(loc_t), .i_remote_one_temp(r1_t),
      .i_remote_two_temp(r2_t), .i_analog_nine_value(a9_t), .o_thermal_override(ovr), .o_irq(irq));
   tls_host_model host (
      .i_mclk(mclk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));

   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // byte compare, four-state exact
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check_val

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.read_reg(a, d);
      check_val(d, exp, "register read");
   endtask : rd_chk

   // override state and interrupt level, settled mid-cycle
   task automatic pins_chk(input logic [1:0] o, input logic q);
      @(negedge mclk);
      check_val({6'h00, ovr}, {6'h00, o}, "override pins");
      check_val({7'h00, irq}, {7'h00, q}, "interrupt pin");
   endtask : pins_chk

   // one conversion cycle with all four results
   task automatic convert(input logic [7:0] l, input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] c);
      @(posedge mclk);
      conv  <= 1'b1;
      loc_t <= l;
      r1_t  <= a;
      r2_t  <= b;
      a9_t  <= c;
      @(posedge mclk);
      conv  <= 1'b0;
   endtask : convert

   // convert with one channel at v, the other quiet at 30h, then check status byte
   task automatic chan_step(input int ch, input logic [7:0] v, input logic f);
      if (ch == 0) convert(8'h00, v, 8'h30, 8'h30);
      else convert(8'h00, 8'h30, v, 8'h30);
      rd_chk(8'h20, {6'h00, f & (ch == 1), f & (ch == 0)});
   endtask : chan_step

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   // watchdog, tests take well under 2000 cycles
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      complete_run();
   end

   logic [7:0] wv [4] = '{8'h65, 8'h64, 8'h0F, 8'h10};
   logic       wf [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   initial begin
      err_total = 0;
      checks    = 0;
      rst_b     = 1'b0;
      conv      = 1'b0;
      loc_t     = 8'h00;
      r1_t      = 8'h00;
      r2_t      = 8'h00;
      a9_t      = 8'h00;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      // reset values, unmapped address
      rd_chk(8'h1F, 8'h00);
      rd_chk(8'h20, 8'h00);
      rd_chk(8'h80, 8'h00);
      rd_chk(8'h21, 8'h64);
      pins_chk(2'b00, 1'b0);
      // local reading follows conversions, writes to it are ignored
      convert(8'h3A, 8'h30, 8'h30, 8'h30);
      host.write_reg(8'h1F, 8'hFF);
      host.write_reg(8'h20, 8'hFF);
      rd_chk(8'h1F, 8'h3A);
      rd_chk(8'h20, 8'h00);
      // keep override out of the way, then window edges per channel
      host.write_reg(8'h23, 8'hFF);
      host.write_reg(8'h26, 8'hFF);
      for (int ch = 0; ch < 2; ch++) begin
         host.write_reg(8'h22 + 8'(3 * ch), 8'h10);
         for (int i = 0; i < 4; i++) chan_step(ch, wv[i], wf[i]);
      end
      // voltage mode: channel two judged on analog input nine
      host.write_reg(8'h27, 8'h01);
      rd_chk(8'h27, 8'h01);
      convert(8'h00, 8'h30, 8'h30, 8'h70);
      rd_chk(8'h20, 8'h02);
      convert(8'h00, 8'h30, 8'h70, 8'h30);
      rd_chk(8'h20, 8'h00);
      host.write_reg(8'h27, 8'h00);
      // override entry, hold, hysteresis boundary, exit, hold
      for (int ch = 0; ch < 2; ch++) begin
         host.write_reg(8'h21 + 8'(3 * ch), 8'hFF);
         host.write_reg(8'h23 + 8'(3 * ch), 8'h55);
         chan_step(ch, 8'h56, 1'b1);
         pins_chk(2'(1 << ch), 1'b0);
         chan_step(ch, 8'h56, 1'b0);
         chan_step(ch, 8'h50, 1'b0);
         pins_chk(2'(1 << ch), 1'b0);
         chan_step(ch, 8'h4F, 1'b1);
         chan_step(ch, 8'h4F, 1'b0);
         pins_chk(2'b00, 1'b0);
      end
      // sticky events, mask, clear by writing ones
      rd_chk(8'h28, 8'h0F);
      host.write_reg(8'h29, 8'h01);
      rd_chk(8'h29, 8'h01);
      pins_chk(2'b00, 1'b1);
      host.write_reg(8'h28, 8'h0F);
      rd_chk(8'h28, 8'h00);
      pins_chk(2'b00, 1'b0);
      chan_step(0, 8'h56, 1'b1);
      pins_chk(2'b01, 1'b1);
      rd_chk(8'h2A, 8'h01);
      host.write_reg(8'h29, 8'h00);
      pins_chk(2'b01, 1'b0);
      // reset in mid-run clears status again
      @(posedge mclk);
      rst_b <= 1'b0;
      @(posedge mclk);
      rst_b <= 1'b1;
      rd_chk(8'h20, 8'h00);
      pins_chk(2'b00, 1'b0);
      complete_run();
   end

endmodule : tls_temp_limit_status_regs_bench
`default_nettype wire

// ===== hdl/tls_chan_mon.sv
// Purpose: window compare and thermal_override tracking for one remote channel
// Assumes: i_sample is a one-cycle strobe with a fresh conversion result
// Notes:   flag and change pulse are registered together on the sample
`timescale 1ns/10ps
`default_nettype none
`include "tls_defs.svh"

module tls_chan_mon (
   // clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_rst_b,
   // conversion result and limits
   input  wire logic              i_sample,
   input  wire tls_pkg::tls_byte_t i_value,
   input  wire tls_pkg::tls_byte_t i_high,
   input  wire tls_pkg::tls_byte_t i_low,
   input  wire tls_pkg::tls_byte_t i_ovr_limit,
   input  wire logic              i_ovr_enable,
   // results
   output logic                   o_flag,
   output logic                   o_flag_set,
   output logic                   o_ovr_change,
   output logic                   o_ovr_active
);

   tls_pkg::tls_ovr_e state_r;
   tls_pkg::tls_ovr_e state_nxt;
   logic              out_win;
   logic              change;

   // window fault on this result, either side
   assign out_win = (i_value > i_high) || (i_value < i_low);

   // engage above the limit, release once more than 5 degrees below it, or at once when disabled
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         tls_pkg::TLS_OVR_OFF: begin
            if (i_ovr_enable && (i_value > i_ovr_limit)) state_nxt = tls_pkg::TLS_OVR_ON; // R4 R7
         end
         tls_pkg::TLS_OVR_ON: begin
            if (!i_ovr_enable) state_nxt = tls_pkg::TLS_OVR_OFF;
            else if (({1'b0, i_value} + `TLS_OVR_HYST) < {1'b0, i_ovr_limit}) begin
               state_nxt = tls_pkg::TLS_OVR_OFF; // R5 R8
            end
         end
         default: state_nxt = tls_pkg::TLS_OVR_OFF;
      endcase
   end

   // only a real transition counts, a mode forced off by disable does not
   assign change = i_ovr_enable && (state_nxt != state_r); // R9

   // override state advances on each sample
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) state_r <= tls_pkg::TLS_OVR_OFF;
      else if (i_sample) state_r <= state_nxt;
   end

   // flag follows the latest result, plus one-time set on a mode edge
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_flag       <= 1'b0;
         o_flag_set   <= 1'b0;
         o_ovr_change <= 1'b0;
      end else begin
         o_flag_set   <= i_sample && (out_win || change);
         o_ovr_change <= i_sample && change; // R9
         if (i_sample) o_flag <= out_win || change; // R3 R6
      end
   end

   assign o_ovr_active = (state_r == tls_pkg::TLS_OVR_ON);

endmodule : tls_chan_mon
`default_nettype wire

// ===== hdl/tls_defs.svh
// Purpose: register offsets, field positions, reset values and release hysteresis of the limit status bank
// Assumes: one byte per address on the plain register port
// Notes:   included by every design file of the bank except the package
`ifndef TLS_DEFS_SVH
`define TLS_DEFS_SVH

// register offsets
`define TLS_ADDR_LOCAL      8'h1F
`define TLS_ADDR_STATUS     8'h20
`define TLS_ADDR_CH_BASE    8'h21
`define TLS_CH_STRIDE       8'h03
`define TLS_OFS_HIGH        8'h00
`define TLS_OFS_LOW         8'h01
`define TLS_OFS_OVR         8'h02
`define TLS_ADDR_CONFIG     8'h27
`define TLS_ADDR_IRQ_STAT   8'h28
`define TLS_ADDR_IRQ_MASK   8'h29
`define TLS_ADDR_OVR_STATE  8'h2A

// field positions
`define TLS_ST_CH1_BIT      0
`define TLS_ST_CH2_BIT      1
`define TLS_CFG_VMODE_BIT   0

// reset values
`define TLS_RST_BYTE        8'h00
`define TLS_RST_HIGH        8'h64
`define TLS_RST_LOW         8'h00
`define TLS_RST_OVR         8'h55
`define TLS_RST_IRQ         4'h0

// override release hysteresis in degrees, one code per degree
`define TLS_OVR_HYST        9'h005

`endif

// ===== hdl/tls_irq.sv
// Purpose: sticky event status, mask and level interrupt
// Assumes: events are one-cycle pulses
// Notes:   a set in the clearing cycle wins so no event is lost
`timescale 1ns/10ps
`default_nettype none
`include "tls_defs.svh"

module tls_irq #(
   parameter int N = 4
) (
   // clock and reset
   input  wire logic         i_mclk,
   input  wire logic         i_rst_b,
   // events and software access
   input  wire logic [N-1:0] i_event,
   input  wire logic         i_clr_wr,
   input  wire logic         i_mask_wr,
   input  wire logic [N-1:0] i_wdata,
   // state
   output logic [N-1:0]      o_status,
   output logic [N-1:0]      o_mask,
   output logic              o_irq
);

   // one sticky bit per event, write one to clear
   for (genvar g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge i_mclk) begin
         if (!i_rst_b) o_status[g] <= 1'b0;
         else if (i_event[g]) o_status[g] <= 1'b1;
         else if (i_clr_wr && i_wdata[g]) o_status[g] <= 1'b0;
      end
   end

   // mask, one enables the bit
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) o_mask <= N'(`TLS_RST_IRQ);
      else if (i_mask_wr) o_mask <= i_wdata;
   end

   assign o_irq = |(o_status & o_mask);

endmodule : tls_irq
`default_nettype wire

// ===== hdl/tls_pkg.sv
// Purpose: shared types of the limit status bank
// Assumes: 8-bit readings and limits
// Notes:   constants live in tls_defs.svh
package tls_pkg;

   typedef logic [7:0] tls_byte_t;

   // thermal_override mode of one remote channel
   typedef enum logic [0:0] {
      TLS_OVR_OFF,
      TLS_OVR_ON
   } tls_ovr_e;

endpackage : tls_pkg

// ===== hdl/tls_temp_limit_status_regs.sv
// Purpose: reading and limit status registers of the thermal monitor
// Assumes: i_conv_valid pulses once per conversion cycle with all results valid
// Notes:   limits, config and interrupt registers sit beside the status byte
//
// Overview of operation
// (R1) local reading register, eight bits, resets zero
// (R2) status register at 20h, clears on reset
// (R3) bit 0: channel one outside window
// (R4) bit 0 set once on override entry
// (R5) bit 0 set once on override exit
// (R6) bit 1: channel two window, analog nine
// (R7) bit 1 set once on override entry
// (R8) bit 1 set once on override exit
// (R9) override flag only on mode edge
`timescale 1ns/10ps
`default_nettype none
`include "tls_defs.svh"

module tls_temp_limit_status_regs #(
   parameter int NCH = 2
) (
   // clock and reset
   input  wire logic               i_mclk,
   input  wire logic               i_rst_b,
   // register port
   input  wire logic [7:0]         i_addr,
   input  wire logic [7:0]         i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   output logic [7:0]              o_rdata,
   // conversion results
   input  wire logic               i_conv_valid,
   input  wire tls_pkg::tls_byte_t i_local_temp,
   input  wire tls_pkg::tls_byte_t i_remote_one_temp,
   input  wire tls_pkg::tls_byte_t i_remote_two_temp,
   input  wire tls_pkg::tls_byte_t i_analog_nine_value,
   // status out
   output logic [NCH-1:0]          o_thermal_override,
   output logic                    o_irq
);

   // register map of the bank, one byte per address:
   //   1Fh local reading, read only, follows each conversion
   //   20h limit status, read only, bit 0 channel one, bit 1 channel two
   //   21h..23h channel one high, low and override limits
   //   24h..26h the same three limits for channel two
   //   27h configuration, bit 0 moves channel two to analog input nine
   //   28h sticky events, write ones to clear
   //   29h event mask, a one lets the event raise the interrupt
   //   2Ah override state of both channels, read only
   // writes to read-only or unmapped addresses are dropped quietly

   tls_pkg::tls_byte_t local_temp_reading_r;
   tls_pkg::tls_byte_t high_r [NCH];
   tls_pkg::tls_byte_t low_r  [NCH];
   tls_pkg::tls_byte_t ovr_r  [NCH];
   tls_pkg::tls_byte_t value  [NCH];
   tls_pkg::tls_byte_t limit_status_one;
   tls_pkg::tls_byte_t rd_mux;
   logic               vmode_r;
   logic [NCH-1:0]     flag;
   logic [NCH-1:0]     flag_set;
   logic [NCH-1:0]     ovr_chg;
   logic [NCH-1:0]     ovr_en;
   logic [3:0]         irq_status;
   logic [3:0]         irq_mask;
   logic               wr_cfg;
   logic               wr_irq_clr;
   logic               wr_irq_mask;

   // local reading captured on every conversion
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) local_temp_reading_r <= `TLS_RST_BYTE; // R1
      else if (i_conv_valid) local_temp_reading_r <= i_local_temp; // R1
   end

   // write enables of the single-byte control registers
   assign wr_cfg      = i_wr && (i_addr == `TLS_ADDR_CONFIG);
   assign wr_irq_clr  = i_wr && (i_addr == `TLS_ADDR_IRQ_STAT);
   assign wr_irq_mask = i_wr && (i_addr == `TLS_ADDR_IRQ_MASK);

   // configuration: voltage measurement mode for channel two
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) vmode_r <= 1'b0;
      else if (wr_cfg) vmode_r <= i_wdata[`TLS_CFG_VMODE_BIT];
   end

   // channel two sees analog input nine in voltage mode
   assign value[0] = i_remote_one_temp;
   assign value[1] = vmode_r ? i_analog_nine_value : i_remote_two_temp; // R6
   // no temperature, so no override, while channel two measures voltage
   assign ovr_en[0] = 1'b1;
   assign ovr_en[1] = !vmode_r;

   // limit registers and monitor per remote channel
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      localparam logic [7:0] BASE = `TLS_ADDR_CH_BASE + 8'(g) * `TLS_CH_STRIDE;

      // limits written by software, they steer the compare
      always_ff @(posedge i_mclk) begin
         if (!i_rst_b) begin
            high_r[g] <= `TLS_RST_HIGH;
            low_r[g]  <= `TLS_RST_LOW;
            ovr_r[g]  <= `TLS_RST_OVR;
         end else if (i_wr) begin
            if (i_addr == BASE + `TLS_OFS_HIGH) high_r[g] <= i_wdata;
            if (i_addr == BASE + `TLS_OFS_LOW) low_r[g] <= i_wdata;
            if (i_addr == BASE + `TLS_OFS_OVR) ovr_r[g] <= i_wdata;
         end
      end

      tls_chan_mon u_mon (
         .i_mclk       (i_mclk),
         .i_rst_b      (i_rst_b),
         .i_sample     (i_conv_valid),
         .i_value      (value[g]),
         .i_high       (high_r[g]),
         .i_low        (low_r[g]),
         .i_ovr_limit  (ovr_r[g]),
         .i_ovr_enable (ovr_en[g]),
         .o_flag       (flag[g]),
         .o_flag_set   (flag_set[g]),
         .o_ovr_change (ovr_chg[g]),
         .o_ovr_active (o_thermal_override[g])
      );
   end

   // status byte, unused bits read zero
   always_comb begin
      limit_status_one = `TLS_RST_BYTE; // R2
      limit_status_one[`TLS_ST_CH1_BIT] = flag[0]; // R3
      limit_status_one[`TLS_ST_CH2_BIT] = flag[1]; // R6
   end

   // interrupt events: flag sets and override transitions
   tls_irq #(
      .N (4)
   ) u_irq (
      .i_mclk    (i_mclk),
      .i_rst_b   (i_rst_b),
      .i_event   ({ovr_chg, flag_set}),
      .i_clr_wr  (wr_irq_clr),
      .i_mask_wr (wr_irq_mask),
      .i_wdata   (i_wdata[3:0]),
      .o_status  (irq_status),
      .o_mask    (irq_mask),
      .o_irq     (o_irq)
   );

   // read decode, unmapped addresses read zero
   always_comb begin
      rd_mux = `TLS_RST_BYTE;
      case (i_addr)
         `TLS_ADDR_LOCAL:     rd_mux = local_temp_reading_r;
         `TLS_ADDR_STATUS:    rd_mux = limit_status_one; // R2
         `TLS_ADDR_CONFIG:    rd_mux = {7'h00, vmode_r};
         `TLS_ADDR_IRQ_STAT:  rd_mux = {4'h0, irq_status};
         `TLS_ADDR_IRQ_MASK:  rd_mux = {4'h0, irq_mask};
         `TLS_ADDR_OVR_STATE: rd_mux = {6'h00, o_thermal_override};
         default: begin
            for (int c = 0; c < NCH; c++) begin
               if (i_addr == `TLS_ADDR_CH_BASE + 8'(c) * `TLS_CH_STRIDE + `TLS_OFS_HIGH) rd_mux = high_r[c];
               if (i_addr == `TLS_ADDR_CH_BASE + 8'(c) * `TLS_CH_STRIDE + `TLS_OFS_LOW) rd_mux = low_r[c];
               if (i_addr == `TLS_ADDR_CH_BASE + 8'(c) * `TLS_CH_STRIDE + `TLS_OFS_OVR) rd_mux = ovr_r[c];
            end
         end
      endcase
   end

   // read data stand only in the cycle after the strobe, zero otherwise
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) o_rdata <= `TLS_RST_BYTE;
      else if (i_rd) o_rdata <= rd_mux;
      else o_rdata <= `TLS_RST_BYTE;
   end

   // ------------------------------------------------------------------
   // checks; helpers below are read only by the properties
   // ------------------------------------------------------------------
   logic [NCH-1:0] win_fault;
   logic [NCH-1:0] ovr_enter;
   logic [NCH-1:0] ovr_leave;

   // window and threshold terms computed from the channel values and limit registers
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         win_fault[c] = (value[c] > high_r[c]) || (value[c] < low_r[c]);
         ovr_enter[c] = ovr_en[c] && !o_thermal_override[c] && (value[c] > ovr_r[c]);
         ovr_leave[c] = ovr_en[c] && o_thermal_override[c]
                        && (({1'b0, value[c]} + `TLS_OVR_HYST) < {1'b0, ovr_r[c]});
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   a_local_capture: assert property (i_conv_valid |=> local_temp_reading_r == $past(i_local_temp)) // R1
      else $error("local reading not captured");

   a_local_hold: assert property (!i_conv_valid |=> $stable(local_temp_reading_r)) // R1
      else $error("local reading changed without conversion");

   a_status_reset: assert property (disable iff (1'b0) !i_rst_b |=> limit_status_one == 8'h00) // R2
      else $error("status not cleared by reset");

   a_status_read: assert property (i_rd && (i_addr == 8'h20) && !i_conv_valid // R2
                                   |=> o_rdata == limit_status_one)
      else $error("status read at 20h wrong");

   a_ch1_window: assert property (i_conv_valid && win_fault[0] |=> flag[0]) // R3
      else $error("channel one window fault not flagged");

   a_ch1_clear: assert property (i_conv_valid && !win_fault[0] && !ovr_enter[0] && !ovr_leave[0] // R3
                                 |=> !flag[0])
      else $error("channel one flag set without cause");

   a_ch1_engage: assert property (i_conv_valid && ovr_enter[0] // R4
                                  |=> flag[0] && o_thermal_override[0] && ovr_chg[0])
      else $error("channel one override entry not flagged");

   a_ch1_release: assert property (i_conv_valid && ovr_leave[0] // R5
                                   |=> flag[0] && !o_thermal_override[0] && ovr_chg[0])
      else $error("channel one override exit not flagged");

   a_ch2_window: assert property (i_conv_valid && (win_fault[1] || ovr_enter[1] || ovr_leave[1]) // R6
                                  |=> flag[1])
      else $error("channel two window fault not flagged");

   a_ch2_clear: assert property (i_conv_valid && !win_fault[1] && !ovr_enter[1] && !ovr_leave[1] // R6
                                 |=> !flag[1])
      else $error("channel two flag set without cause");

   a_ch2_engage: assert property (i_conv_valid && ovr_enter[1] // R7
                                  |=> flag[1] && o_thermal_override[1])
      else $error("channel two override entry not flagged");

   a_ch2_release: assert property (i_conv_valid && ovr_leave[1] // R8
                                   |=> flag[1] && !o_thermal_override[1])
      else $error("channel two override exit not flagged");

   a_ovr_edge_only: assert property (ovr_chg[0] |-> o_thermal_override[0] != $past(o_thermal_override[0])) // R9
      else $error("override change pulse without mode edge");

   a_ovr_edge_two: assert property (ovr_chg[1] |-> o_thermal_override[1] != $past(o_thermal_override[1])) // R9
      else $error("channel two change pulse without mode edge");

   a_irq_level: assert property (flag_set[0] && irq_mask[0] && !i_wr
      |=> o_irq)
      else $error("unmasked event did not raise interrupt");

   a_read_once: assert property (!i_rd |=> o_rdata == 8'h00)
      else $error("read data held past its cycle");

   // reading register and read port
   a_local_reset: assert property (disable iff (1'b0) !i_rst_b // R1
      |=> local_temp_reading_r == `TLS_RST_BYTE)
      else $error("local reading not reset");

   a_local_read: assert property (i_rd && (i_addr == `TLS_ADDR_LOCAL) // R1
      |=> o_rdata == $past(local_temp_reading_r))
      else $error("local read wrong");

   a_ovr_read: assert property (i_rd && (i_addr == `TLS_ADDR_OVR_STATE)
      |=> o_rdata == {6'h00, $past(o_thermal_override)})
      else $error("override state read wrong");

   a_unmapped_read: assert property (i_rd && (i_addr > `TLS_ADDR_OVR_STATE)
      |=> o_rdata == 8'h00)
      else $error("unmapped read not zero");

   // status byte
   a_status_unused: assert property (limit_status_one[7:2] == 6'h00) // R2
      else $error("unused status bits set");

   a_status_hold: assert property (!i_conv_valid // R3 R6
      |=> $stable(flag))
      else $error("status moved without conversion");

   a_flagset_match: assert property (i_conv_valid // R3 R6
      |=> flag_set == flag)
      else $error("flag set event disagrees with flag");

   a_flagset_idle: assert property (!i_conv_valid
      |=> flag_set == '0)
      else $error("flag set event without conversion");

   // override tracking
   a_ovr_hold: assert property (!i_conv_valid // R9
      |=> $stable(o_thermal_override))
      else $error("override moved without conversion");

   a_chg_needs_sample: assert property (!i_conv_valid // R9
      |=> ovr_chg == '0)
      else $error("override change without conversion");

   a_ch2_enter_chg: assert property (i_conv_valid && ovr_enter[1] // R7
      |=> ovr_chg[1])
      else $error("channel two entry event missing");

   a_ch2_leave_chg: assert property (i_conv_valid && ovr_leave[1] // R8
      |=> ovr_chg[1])
      else $error("channel two exit event missing");

   a_ch2_vmode: assert property (vmode_r && i_conv_valid // R6
      |=> !o_thermal_override[1] && !ovr_chg[1])
      else $error("override active in voltage mode");

   // software registers
   a_limit_reset: assert property (disable iff (1'b0) !i_rst_b
      |=> high_r[0] == `TLS_RST_HIGH && low_r[0] == `TLS_RST_LOW && ovr_r[0] == `TLS_RST_OVR)
      else $error("limits not reset");

   a_ctrl_reset: assert property (disable iff (1'b0) !i_rst_b
      |=> !vmode_r && o_thermal_override == '0 && o_rdata == 8'h00)
      else $error("control state not reset");

   a_high_write: assert property (i_wr && (i_addr == `TLS_ADDR_CH_BASE)
      |=> high_r[0] == $past(i_wdata))
      else $error("high limit write lost");

   a_ovr_limit_write: assert property (i_wr && (i_addr == 8'h26)
      |=> ovr_r[1] == $past(i_wdata))
      else $error("override limit write lost");

   a_cfg_write: assert property (wr_cfg
      |=> vmode_r == $past(i_wdata[`TLS_CFG_VMODE_BIT]))
      else $error("config write lost");

   a_mask_write: assert property (wr_irq_mask
      |=> irq_mask == $past(i_wdata[3:0]))
      else $error("mask write lost");

   // events and interrupt
   a_irq_reset: assert property (disable iff (1'b0) !i_rst_b
      |=> irq_status == 4'h0 && irq_mask == 4'h0 && !o_irq)
      else $error("interrupt state not reset");

   a_irq_set_wins: assert property (flag_set[0]
      |=> irq_status[0])
      else $error("event not made sticky");

   a_irq_clear: assert property (wr_irq_clr && i_wdata[0] && !flag_set[0]
      |=> !irq_status[0])
      else $error("sticky event not cleared");

   c_ch1_fault: cover property (i_conv_valid && win_fault[0] ##1 flag[0]);
   c_ch1_cycle: cover property (ovr_chg[0] && o_thermal_override[0] ##[1:50] ovr_chg[0]);
   c_ch2_volt:  cover property (vmode_r && i_conv_valid && win_fault[1] ##1 flag[1]);
   c_irq_clear: cover property (o_irq ##1 (i_wr && (i_addr == 8'h28)) ##1 !o_irq);
   c_ch2_ovr:   cover property (ovr_chg[1] && o_thermal_override[1]);

endmodule : tls_temp_limit_status_regs
`default_nettype wire
